// file: trace_report.sv
// instruction trace reporting around debug events, with output fifo
`timescale 1ns/100ps
`default_nettype none
`include "trace_report_cfg.svh"

module trace_fifo #(
    parameter int width = 32,
    parameter int depth = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int aw = (depth > 1) ? $clog2(depth) : 1;
    initial begin
        if (depth < 2 || (depth & (depth - 1)) != 0)
            $error("trace_fifo depth must be a power of two >= 2");
    end
    logic [width-1:0] mem_ff [depth];
    // one spare pointer bit tells a full fifo from an empty one
    logic [aw:0] wr_ff;
    logic [aw:0] rd_ff;
    logic [aw:0] nxt_wr;
    logic [aw:0] nxt_rd;
    logic push;
    logic pop;
    assign in_ready = (wr_ff - rd_ff) != (aw+1)'(depth);
    assign out_valid = wr_ff != rd_ff;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ff[aw-1:0]];
    always_comb begin
        nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end
    // storage needs no reset: a word is only read after it was written
    always_ff @(posedge clk_sys) begin
        if (push)
            mem_ff[wr_ff[aw-1:0]] <= in_data;
    end
endmodule : trace_fifo

// What this block does
// - two status bits select halt, monitor, none
// - monitor watchpoint exception suppresses the instruction trace
// - exact comparator fires only on executed instructions
// - trace last completed instruction before external halt
// - partial load/store multiple at halt not traced
// - halt on external request or run control write
// - absent simd/upper register bits read 11
module trace_report #(
    parameter int addr_width = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // debug configuration
    input wire logic [1:0] debug_status_control_reg,
    input wire logic invasive_debug_enable,
    input wire logic external_halt_request,
    input wire logic debug_run_control_reg,
    // retirement from the pipeline
    input wire logic retire_valid,
    input wire logic [addr_width-1:0] retire_addr,
    input wire logic retire_complete,
    input wire logic watchpoint_hit,
    // comparator setup
    input wire logic [addr_width-1:0] compare_addr,
    input wire logic compare_exact,
    // trace stream out
    output logic trace_valid,
    input wire logic trace_ready,
    output logic [addr_width-1:0] trace_addr,
    // status
    output logic [1:0] debug_mode,
    output logic halted,
    output logic watch_exception,
    output logic compare_fire,
    output logic [7:0] trigger_count,
    output logic [1:0] coprocessor_access_control,
    output logic core_stall
);
    initial begin
        if (addr_width < 2)
            $error("trace_report addr_width too small");
        if (`FIFO_DEPTH < 2)
            $error("trace_report fifo depth too small");
    end
    trace_report_pkg::run_state_type state_ff;
    trace_report_pkg::run_state_type nxt_state;
    logic [1:0] mode_ff;
    logic [1:0] nxt_mode;
    logic watch_ff;
    logic nxt_watch;
    logic fire_ff;
    logic nxt_fire;
    logic [7:0] trig_ff;
    logic [7:0] nxt_trig;
    logic [1:0] cpac_ff;
    logic halt_req;
    logic monitor_on;
    logic suppress;
    logic executed;
    logic push;
    logic fifo_ready;

    function automatic logic addr_match(input logic [addr_width-1:0] a,
                                        input logic [addr_width-1:0] b);
        addr_match = (a == b);
    endfunction : addr_match

    // mode value 3 is reserved and behaves as no debug mode
    function automatic logic mode_is_monitor(input logic [1:0] m);
        mode_is_monitor = (m == trace_report_pkg::mode_monitor_type_v);
    endfunction : mode_is_monitor

    assign halt_req = external_halt_request || debug_run_control_reg;
    assign monitor_on = invasive_debug_enable && mode_is_monitor(mode_ff);
    // a monitor-mode data watchpoint aborts the instruction before it retires
    // only a real retirement can take the watchpoint exception
    assign suppress = retire_valid && monitor_on &&
        watchpoint_hit;
    // partial multi-transfer work is never a completed instruction
    assign executed = retire_valid && retire_complete && !suppress &&
        (state_ff == trace_report_pkg::st_run);
    // a full fifo stalls retirement rather than losing trace
    assign push = executed && fifo_ready;
    assign core_stall = !fifo_ready;

    always_comb begin
        nxt_mode = mode_ff;
        nxt_state = state_ff;
        nxt_watch = suppress;
        nxt_fire = 1'b0;
        nxt_trig = trig_ff;
        // mode bits are taken from the status/control field
        nxt_mode = debug_status_control_reg;
        case (state_ff)
            trace_report_pkg::st_run: begin
                // the instruction retiring this cycle is still reported
                if (halt_req)
                    nxt_state = trace_report_pkg::st_halting;
            end
            // halting gives the pipeline one cycle to drain
            trace_report_pkg::st_halting: begin
                nxt_state = trace_report_pkg::st_halted;
            end
            trace_report_pkg::st_halted: begin
                if (!halt_req)
                    nxt_state = trace_report_pkg::st_run;
            end
            default: nxt_state = trace_report_pkg::st_run;
        endcase
        if (push && compare_exact &&
            addr_match(retire_addr, compare_addr)) begin
            nxt_fire = 1'b1;
        end
        // triggers count only traced matches; the count wraps at 255
        if (nxt_fire) begin
            nxt_trig = trig_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= trace_report_pkg::st_run;
            mode_ff <= `MODE_RESET;
            watch_ff <= 1'b0;
            fire_ff <= 1'b0;
            trig_ff <= 8'h00;
            cpac_ff <= `CPAC_DIS_ABSENT;
        end else begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            watch_ff <= nxt_watch;
            fire_ff <= nxt_fire;
            trig_ff <= nxt_trig;
            cpac_ff <= `CPAC_DIS_ABSENT;
        end
    end

    // a full fifo holds the pipeline, but a held retirement that completes after the state has left st_run is not traced
    trace_fifo #(
        .width(addr_width),
        .depth(`FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(executed),
        .in_ready(fifo_ready),
        .in_data(retire_addr),
        .out_valid(trace_valid),
        .out_ready(trace_ready),
        .out_data(trace_addr)
    );

    assign debug_mode = mode_ff;
    assign halted = (state_ff == trace_report_pkg::st_halted);
    assign watch_exception = watch_ff;
    assign compare_fire = fire_ff;
    assign trigger_count = trig_ff;
    assign coprocessor_access_control = cpac_ff;
endmodule : trace_report
`default_nettype wire

// file: trace_report_cfg.svh
// constants for the debug trace reporting block
`ifndef TRACE_REPORT_CFG_SVH
`define TRACE_REPORT_CFG_SVH
`define DSCR_MODE_HI 15
`define DSCR_MODE_LO 14
`define CPAC_DIS_HI 31
`define CPAC_DIS_LO 30
`define CPAC_DIS_ABSENT 2'h3
`define MODE_RESET 2'h0
`define FIFO_DEPTH 4
`endif

// file: trace_report_pkg.sv
// types for the debug trace reporting block
package trace_report_pkg;
    typedef enum logic [1:0] {
        mode_none_type_v = 2'h0,
        mode_halt_type_v = 2'h1,
        mode_monitor_type_v = 2'h2
    } debug_mode_type;
    typedef enum logic [1:0] {
        st_run = 2'h0,
        st_halting = 2'h1,
        st_halted = 2'h3
    } run_state_type;
endpackage : trace_report_pkg

// file: trace_report_props.sv
// assertions on trace_report ports
`timescale 1ns/100ps
`default_nettype none
module trace_report_props #(parameter int addr_width = 32) (
    input wire logic clk_sys, rst, retire_valid, retire_complete, halted,
    input wire logic invasive_debug_enable, watchpoint_hit, compare_exact,
    input wire logic external_halt_request, debug_run_control_reg,
    input wire logic core_stall, watch_exception, compare_fire,
    input wire logic [1:0] debug_status_control_reg, debug_mode,
    input wire logic [1:0] coprocessor_access_control,
    input wire logic [addr_width-1:0] retire_addr, compare_addr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire hit = retire_valid && retire_complete && compare_exact &&
        retire_addr == compare_addr;
    wire mon = retire_valid && watchpoint_hit && invasive_debug_enable &&
        debug_mode == 2'h2;
    wire req = external_halt_request || debug_run_control_reg;
    sequence s_req_held; req ##1 req; endsequence
    a_mode_field: assert property (
        debug_status_control_reg != 2'h3 |=>
        debug_mode == $past(debug_status_control_reg)) else $error("mode");
    a_watch_quiet: assert property (mon |=> !compare_fire)
        else $error("watch fired");
    a_watch_cause: assert property (watch_exception |-> $past(mon))
        else $error("stray watch");
    a_fire_cause: assert property (compare_fire |-> $past(hit))
        else $error("stray fire");
    a_halt_entry: assert property (s_req_held |=> halted)
        else $error("no halt");
    a_halt_quiet: assert property (halted |=> !compare_fire)
        else $error("fire halted");
    a_last_trace: assert property (
        req && !$past(req) && !halted && hit && !mon && !core_stall
        |=> compare_fire) else $error("last lost");
    a_cpac_fixed: assert property (coprocessor_access_control == 2'h3)
        else $error("cpac");
endmodule : trace_report_props
bind trace_report trace_report_props #(.addr_width(addr_width)) props_i (.*);
`default_nettype wire

// file: trace_report_tb.sv
// random and directed tests for trace_report
`timescale 1ns/100ps
`default_nettype none
module trace_report_tb;
    logic clk_sys = 0, rst = 1, xh = 0, rc = 0, rv = 0, cm = 0, wp = 0;
    logic en = 0, hz = 0, rdy, tv, st, hl;
    logic [1:0] md = 0, cp, dm;
    logic [31:0] ad = 0, ta, q[$];
    logic [7:0] tc;
    int seed = 80267, failures = 0, samples_checked = 0, n = 0, i, k;
    always #5 clk_sys = ~clk_sys;
    trace_report trace_report_i (.clk_sys(clk_sys), .rst(rst),
        .debug_status_control_reg(md), .invasive_debug_enable(en),
        .external_halt_request(xh), .debug_run_control_reg(rc),
        .retire_valid(rv), .retire_addr(ad), .retire_complete(cm),
        .watchpoint_hit(wp), .compare_addr(32'h2), .compare_exact(1'b1),
        .trace_valid(tv), .trace_ready(rdy), .trace_addr(ta), .debug_mode(dm),
        .halted(hl), .watch_exception(), .compare_fire(), .trigger_count(tc),
        .coprocessor_access_control(cp), .core_stall(st));
    trace_sink trace_sink_i (.clk_sys(clk_sys), .trace_valid(tv),
        .trace_addr(ta), .trace_ready(rdy));
    task chk(input string nm, input logic [31:0] seen, want);
        samples_checked++;
        if (seen !== want) begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", nm, want, seen);
        end
    endtask : chk
    task final_report;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    function logic kept(logic e, c, w);
        return c && !(md == 2'h2 && e && w) && !hz;
    endfunction : kept
    // a full fifo stalls the retirement, so it is held until core_stall falls
    task put(input logic e, c, w, input logic [31:0] a);
        en <= e; cm <= c; wp <= w; ad <= a; rv <= 1;
        for (k = 0; k < 50; k++) begin
            @(negedge clk_sys);
            if (st === 1'b0) break;
            @(posedge clk_sys);
        end
        @(posedge clk_sys);
        if (k == 50) begin failures++; final_report; end
        if (kept(e, c, w)) begin q.push_back(a); n += int'(a == 2); end
    endtask : put
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        for (i = 0; i < 256; i++) begin
            if (i % 32 == 0) begin
                rv <= 0; md <= 2'($random(seed));
                repeat (2) @(posedge clk_sys);
            end
            put(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
                32'($random(seed)) & 32'h3);
        end
        rv <= 0; md <= 2'h1;
        repeat (2) @(posedge clk_sys);
        xh <= 1;
        put(1'b1, 1'b1, 1'b0, 32'h2);
        hz = 1;
        put(1'b1, 1'b1, 1'b0, 32'h2);
        rv <= 0;
        repeat (2) @(negedge clk_sys);
        chk("halted", hl, 1);
        @(posedge clk_sys);
        xh <= 0;
        repeat (4) @(posedge clk_sys);
        rc <= 1;
        repeat (3) @(posedge clk_sys);
        rc <= 0;
        @(negedge clk_sys);
        chk("halted", hl, 1);
        for (k = 0; k < 500 && trace_sink_i.got.size() < q.size(); k++)
            @(posedge clk_sys);
        chk("words", trace_sink_i.got.size(), q.size());
        foreach (q[j]) chk("trace", trace_sink_i.got[j], q[j]);
        chk("trigger", tc, n);
        chk("cpac", cp, 2'h3);
        chk("mode", dm, 2'h1);
        $display("stream and halt tests done");
        final_report;
    end
endmodule : trace_report_tb
`default_nettype wire

// file: trace_sink.sv
// trace unit model: takes the trace stream, stalling at random
`timescale 1ns/100ps
`default_nettype none
module trace_sink (
    input wire logic clk_sys, trace_valid,
    input wire logic [31:0] trace_addr,
    output var logic trace_ready
);
    logic [31:0] got[$];
    int seed = 80267;
    // cancelled words never arrive, so nothing is discarded here
    always @(posedge clk_sys) begin
        if (trace_valid && trace_ready) got.push_back(trace_addr);
        trace_ready <= 2'($random(seed)) == 2'h0;
    end
endmodule : trace_sink
`default_nettype wire
